// File: rtl/bvf_pkg.sv
/*
 Constants, register map and enumerations of the bit-plane video fetch and shift block.
 Assumes a 20 MHz system clock and a byte-addressed display memory.
*/
package bvf_pkg;
    localparam int ADDR_W           = 24;
    localparam int WORD_W           = 16;
    localparam int PIX_PER_WORD     = 16;
    localparam int PAL_N            = 16;
    localparam int RGB_W            = 12;
    localparam int FIFO_DEPTH       = 8;
    localparam int SCREEN_BYTES     = 32000;
    localparam int WORD_BYTES       = 2;
    localparam int SCREEN_WORDS     = SCREEN_BYTES / WORD_BYTES;
    localparam int LINE_WORDS_COLOR = 80;
    localparam int LINE_WORDS_MONO  = 40;
    localparam int PLANES_LOW       = 4;
    localparam int PLANES_MED       = 2;
    localparam int PLANES_MONO      = 1;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_BASE_HI    = 8'h04;
    localparam logic [7:0] REG_BASE_MID   = 8'h08;
    localparam logic [7:0] REG_BASE_LO    = 8'h0C;
    localparam logic [7:0] REG_SCROLL     = 8'h10;
    localparam logic [7:0] REG_LINE_WIDTH = 8'h14;
    localparam logic [7:0] REG_COUNT      = 8'h18;
    localparam logic [7:0] REG_PAL_FIRST  = 8'h40;
    localparam logic [7:0] REG_PAL_LAST   = 8'h7C;
    // Control fields and reset values
    localparam int         CTRL_EN_BIT    = 0;
    localparam int         CTRL_MODE_LSB  = 1;
    localparam logic [2:0] CTRL_RST       = 3'h0;
    localparam logic [7:0] BYTE_RST       = 8'h00;
    typedef enum logic [1:0] {
        BVF_LOW  = 2'h0,
        BVF_MED  = 2'h1,
        BVF_MONO = 2'h2
    } bvf_mode_e;
    typedef enum logic [1:0] {
        F_IDLE = 2'h0,
        F_WAIT = 2'h1,
        F_REQ  = 2'h3,
        F_ADV  = 2'h2
    } bvf_fetch_e;
endpackage

// File: rtl/bvf_top.sv
/*
 Display word FIFO and the bit-plane video fetch and shift block with its Wishbone registers.
 Assumes frame, line, display-enable and pixel tick strobes and the memory controller share clk_i.
*/
`timescale 1ns/10ps
`default_nettype none

module bvf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             clear_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = mem_reg[rp_reg];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb begin
        wp_next  = push ? AW'(wp_reg + 1'b1) : wp_reg;
        rp_next  = pop ? AW'(rp_reg + 1'b1) : rp_reg;
        cnt_next = (AW+1)'(cnt_reg + push - pop);
        if (clear_i) begin
            wp_next  = '0;
            rp_next  = '0;
            cnt_next = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
        if (push) begin
            mem_reg[wp_reg] <= in_data_i;
        end
    end
endmodule // bvf_fifo

// How it works
// RL1: Display memory holds 1, 2 or 4 interleaved planes.
// RL2: Fetch 32000 bytes from an even start.
// RL3: Frame start copies base into address counter.
// RL4: Counter advances on every plane word read.
// RL5: Controller hands over one 16-bit word each.
// RL6: Monochrome shows each bit as one pixel.
// RL7: Low resolution takes four words per 16 pixels.
// RL8: Same bit from every plane forms palette index.
// RL9: Scroll value 0-15 skips pixels of first word.
// RL10: Each scroll step moves image one pixel left.
// RL11: Line end adds extra width words to address.
// RL12: Sixteen palette entries of 12-bit colour.
// RL13: Entries usable: 16 low, 4 medium, 1 mono.
// RL14: Mono uses palette zero bit 0 as inverse.
// RL15: Medium takes two words, 2-bit index.
module bvf_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        frame_start_i,
    input  wire logic        line_start_i,
    input  wire logic        de_i,
    input  wire logic        pix_tick_i,
    output logic             mem_req_o,
    output logic      [23:0] mem_addr_o,
    input  wire logic        mem_ack_i,
    input  wire logic [15:0] mem_data_i,
    output logic      [11:0] rgb_o,
    output logic             mono_o,
    output logic             pix_valid_o
);
    localparam int NP = bvf_pkg::PLANES_LOW;
    localparam int WW = bvf_pkg::WORD_W;

    logic [2:0]  ctrl_reg, ctrl_next;
    logic [23:0] base_reg, base_next;
    logic [3:0]  scroll_reg, scroll_next;
    logic [7:0]  extra_reg, extra_next;
    logic [11:0] pal_reg [bvf_pkg::PAL_N];
    logic [11:0] pal_next [bvf_pkg::PAL_N];
    logic [31:0] rdat_reg, rdat_next;
    logic        ack_reg, wb_hit, wb_wr;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wb_wr  = wb_hit & wb_we_i;

    localparam int EN_BIT      = bvf_pkg::CTRL_EN_BIT;
    localparam int MODE_LSB    = bvf_pkg::CTRL_MODE_LSB;
    localparam int BYTE_W      = 8;
    localparam int HI_LSB      = 16;
    localparam int MID_LSB     = 8;
    localparam int PAL_IDX_LSB = 2;
    localparam int IDX_W       = $clog2(bvf_pkg::PAL_N);
    localparam int POS_W       = $clog2(bvf_pkg::PIX_PER_WORD);
    localparam int WCNT_W      = $clog2(bvf_pkg::LINE_WORDS_COLOR + 1);
    localparam int TOT_W       = $clog2(bvf_pkg::SCREEN_WORDS + 1);
    localparam int CCNT_W      = $clog2(NP + 1);
    localparam int PLW         = $clog2(NP);

    logic                en;
    logic                mode_med;
    logic                mode_mono;
    logic [CCNT_W-1:0]   planes;
    logic [WCNT_W-1:0]   line_words;
    logic                pal_hit;
    logic [IDX_W-1:0]    pal_sel;
    logic [31:0]         rd_val;
    logic [31:0]         wdat;
    logic                ack_next;
    bvf_pkg::bvf_fetch_e fstate_reg, fstate_next;
    logic [23:0]         vaddr_reg, vaddr_next;
    logic                req_reg, req_next;
    logic [WCNT_W-1:0]   wcnt_reg, wcnt_next;
    logic [TOT_W-1:0]    total_reg, total_next;
    logic                take;
    logic                fifo_clr;
    logic                fifo_rdy;
    logic                fifo_vld;
    logic                fifo_pop;
    logic [WW-1:0]       fifo_dat;
    logic [WW-1:0]       col_reg [NP];
    logic [WW-1:0]       col_next [NP];
    logic [WW-1:0]       disp_reg [NP];
    logic [WW-1:0]       disp_next [NP];
    logic [CCNT_W-1:0]   ccnt_reg, ccnt_next;
    logic                dvalid_reg, dvalid_next;
    logic                first_reg, first_next;
    logic [POS_W-1:0]    pos_reg, pos_next;
    logic                tick;
    logic                load;
    logic [IDX_W-1:0]    pix_idx;
    logic [11:0]         rgb_reg, rgb_next;
    logic                mono_reg, mono_next;
    logic                pv_reg, pv_next;

    // Mode decode
    always_comb begin
        en         = ctrl_reg[EN_BIT];
        mode_mono  = ctrl_reg[MODE_LSB + 1];
        mode_med   = (ctrl_reg[MODE_LSB +: 2] == bvf_pkg::BVF_MED);
        planes     = CCNT_W'(bvf_pkg::PLANES_LOW); // RL1 RL7
        line_words = WCNT_W'(bvf_pkg::LINE_WORDS_COLOR);
        if (mode_mono) begin
            planes     = CCNT_W'(bvf_pkg::PLANES_MONO); // RL6
            line_words = WCNT_W'(bvf_pkg::LINE_WORDS_MONO);
        end else if (mode_med) begin
            planes     = CCNT_W'(bvf_pkg::PLANES_MED); // RL15
        end
    end

    // Register read mux
    always_comb begin
        pal_hit = (wb_adr_i >= bvf_pkg::REG_PAL_FIRST) && (wb_adr_i <= bvf_pkg::REG_PAL_LAST)
                  && (wb_adr_i[PAL_IDX_LSB-1:0] == '0);
        pal_sel = wb_adr_i[PAL_IDX_LSB +: IDX_W];
        rd_val  = '0;
        if (pal_hit) begin
            rd_val = 32'(pal_reg[pal_sel]);
        end else if (wb_adr_i == bvf_pkg::REG_CTRL) begin
            rd_val = 32'(ctrl_reg);
        end else if (wb_adr_i == bvf_pkg::REG_BASE_HI) begin
            rd_val = 32'(base_reg[HI_LSB +: BYTE_W]);
        end else if (wb_adr_i == bvf_pkg::REG_BASE_MID) begin
            rd_val = 32'(base_reg[MID_LSB +: BYTE_W]);
        end else if (wb_adr_i == bvf_pkg::REG_BASE_LO) begin
            rd_val = 32'(base_reg[BYTE_W-1:0]);
        end else if (wb_adr_i == bvf_pkg::REG_SCROLL) begin
            rd_val = 32'(scroll_reg);
        end else if (wb_adr_i == bvf_pkg::REG_LINE_WIDTH) begin
            rd_val = 32'(extra_reg);
        end else if (wb_adr_i == bvf_pkg::REG_COUNT) begin
            rd_val = 32'(vaddr_reg);
        end
    end

    // Register writes and bus answer
    always_comb begin
        ctrl_next   = ctrl_reg;
        base_next   = base_reg;
        scroll_next = scroll_reg;
        extra_next  = extra_reg;
        for (int i = 0; i < bvf_pkg::PAL_N; i++) begin
            pal_next[i] = pal_reg[i];
        end
        wdat      = merge(rd_val, wb_dat_i, wb_sel_i);
        ack_next  = wb_hit;
        rdat_next = (wb_hit && !wb_we_i) ? rd_val : '0;
        if (wb_wr) begin
            if (pal_hit) begin
                pal_next[pal_sel] = wdat[11:0]; // RL12
            end else if (wb_adr_i == bvf_pkg::REG_CTRL) begin
                ctrl_next = wdat[$bits(ctrl_reg)-1:0];
            end else if (wb_adr_i == bvf_pkg::REG_BASE_HI) begin
                base_next[HI_LSB +: BYTE_W] = wdat[BYTE_W-1:0];
            end else if (wb_adr_i == bvf_pkg::REG_BASE_MID) begin
                base_next[MID_LSB +: BYTE_W] = wdat[BYTE_W-1:0];
            end else if (wb_adr_i == bvf_pkg::REG_BASE_LO) begin
                base_next[BYTE_W-1:0] = {wdat[BYTE_W-1:1], 1'h0}; // RL2
            end else if (wb_adr_i == bvf_pkg::REG_SCROLL) begin
                scroll_next = wdat[$bits(scroll_reg)-1:0]; // RL9
            end else if (wb_adr_i == bvf_pkg::REG_LINE_WIDTH) begin
                extra_next = wdat[$bits(extra_reg)-1:0]; // RL11
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg   <= bvf_pkg::CTRL_RST;
            base_reg   <= '0;
            scroll_reg <= '0;
            extra_reg  <= bvf_pkg::BYTE_RST;
            rdat_reg   <= '0;
            ack_reg    <= 1'h0;
            for (int i = 0; i < bvf_pkg::PAL_N; i++) begin
                pal_reg[i] <= '0;
            end
        end else begin
            ctrl_reg   <= ctrl_next;
            base_reg   <= base_next;
            scroll_reg <= scroll_next;
            extra_reg  <= extra_next;
            rdat_reg   <= rdat_next;
            ack_reg    <= ack_next;
            for (int i = 0; i < bvf_pkg::PAL_N; i++) begin
                pal_reg[i] <= pal_next[i];
            end
        end
    end

    assign take     = req_reg & mem_ack_i;
    assign fifo_clr = frame_start_i | ~en;

    // Display word fetch
    always_comb begin
        fstate_next = fstate_reg;
        vaddr_next  = vaddr_reg;
        req_next    = 1'h0;
        wcnt_next   = wcnt_reg;
        total_next  = total_reg;
        if (!en) begin
            fstate_next = bvf_pkg::F_IDLE;
        end else if (frame_start_i) begin
            fstate_next = bvf_pkg::F_WAIT;
            vaddr_next  = base_reg; // RL3
            total_next  = '0;
        end else begin
            unique case (fstate_reg)
                bvf_pkg::F_IDLE: begin
                    fstate_next = bvf_pkg::F_IDLE;
                end
                bvf_pkg::F_WAIT: begin
                    if (line_start_i && (total_reg < TOT_W'(bvf_pkg::SCREEN_WORDS))) begin // RL2
                        fstate_next = bvf_pkg::F_REQ;
                        wcnt_next   = '0;
                    end
                end
                bvf_pkg::F_REQ: begin
                    if (take) begin
                        vaddr_next = 24'(vaddr_reg + 24'(bvf_pkg::WORD_BYTES)); // RL4
                        wcnt_next  = WCNT_W'(wcnt_reg + 1'h1);
                        total_next = TOT_W'(total_reg + 1'h1);
                        if (WCNT_W'(wcnt_reg + 1'h1) == line_words) begin
                            fstate_next = bvf_pkg::F_ADV;
                        end
                    end else begin
                        req_next = fifo_rdy; // RL5
                    end
                end
                bvf_pkg::F_ADV: begin
                    vaddr_next  = 24'(vaddr_reg + 24'({extra_reg, 1'h0})); // RL11
                    fstate_next = bvf_pkg::F_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fstate_reg <= bvf_pkg::F_IDLE;
            vaddr_reg  <= '0;
            req_reg    <= 1'h0;
            wcnt_reg   <= '0;
            total_reg  <= '0;
        end else begin
            fstate_reg <= fstate_next;
            vaddr_reg  <= vaddr_next;
            req_reg    <= req_next;
            wcnt_reg   <= wcnt_next;
            total_reg  <= total_next;
        end
    end

    bvf_fifo #(
        .WIDTH (WW),
        .DEPTH (bvf_pkg::FIFO_DEPTH)
    ) i_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .clear_i     (fifo_clr),
        .in_valid_i  (take),
        .in_ready_o  (fifo_rdy),
        .in_data_i   (mem_data_i),
        .out_valid_o (fifo_vld),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_dat)
    );

    assign fifo_pop = fifo_vld & (ccnt_reg < planes) & ~fifo_clr;

    // Plane collector and pixel shifter
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            col_next[i]  = col_reg[i];
            disp_next[i] = disp_reg[i];
        end
        ccnt_next   = ccnt_reg;
        dvalid_next = dvalid_reg;
        first_next  = first_reg | line_start_i;
        pos_next    = pos_reg;
        tick        = pix_tick_i & de_i & dvalid_reg;
        pix_idx     = '0;
        for (int i = 0; i < NP; i++) begin
            if (CCNT_W'(i) < planes) begin
                pix_idx[i] = disp_reg[i][pos_reg]; // RL8 RL13 RL15
            end
        end
        if (fifo_pop) begin
            col_next[ccnt_reg[PLW-1:0]] = fifo_dat; // RL5 RL7
            ccnt_next                   = CCNT_W'(ccnt_reg + 1'h1);
        end
        if (tick) begin
            pos_next = POS_W'(pos_reg + 1'h1);
            if (pos_reg == POS_W'(bvf_pkg::PIX_PER_WORD - 1)) begin
                dvalid_next = 1'h0;
            end
        end
        load = (ccnt_reg == planes) && !dvalid_next;
        if (load) begin
            for (int i = 0; i < NP; i++) begin
                disp_next[i] = col_reg[i];
            end
            ccnt_next   = '0;
            dvalid_next = 1'h1;
            pos_next    = first_reg ? scroll_reg : '0; // RL9 RL10
            first_next  = line_start_i;
        end
        if (fifo_clr) begin
            ccnt_next   = '0;
            dvalid_next = 1'h0;
            first_next  = 1'h1;
        end
        pv_next   = tick;
        rgb_next  = '0;
        mono_next = 1'h0;
        if (tick) begin
            if (mode_mono) begin
                mono_next = disp_reg[0][pos_reg] ^ pal_reg[0][0]; // RL6 RL14
            end else begin
                rgb_next = pal_reg[pix_idx]; // RL8 RL12
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NP; i++) begin
                col_reg[i]  <= '0;
                disp_reg[i] <= '0;
            end
            ccnt_reg   <= '0;
            dvalid_reg <= 1'h0;
            first_reg  <= 1'h1;
            pos_reg    <= '0;
            rgb_reg    <= '0;
            mono_reg   <= 1'h0;
            pv_reg     <= 1'h0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                col_reg[i]  <= col_next[i];
                disp_reg[i] <= disp_next[i];
            end
            ccnt_reg   <= ccnt_next;
            dvalid_reg <= dvalid_next;
            first_reg  <= first_next;
            pos_reg    <= pos_next;
            rgb_reg    <= rgb_next;
            mono_reg   <= mono_next;
            pv_reg     <= pv_next;
        end
    end

    assign wb_dat_o    = rdat_reg;
    assign wb_ack_o    = ack_reg;
    assign mem_req_o   = req_reg;
    assign mem_addr_o  = vaddr_reg;
    assign rgb_o       = rgb_reg;
    assign mono_o      = mono_reg;
    assign pix_valid_o = pv_reg;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_mem_wait;
        mem_req_o && !mem_ack_i && en && !frame_start_i;
    endsequence

    ack_one_a: assert property (s_bus_req |=> wb_ack_o)
        else $error("bus request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer longer than one cycle");
    frame_load_a: assert property (frame_start_i && en |=> mem_addr_o == $past(base_reg)) // RL3
        else $error("frame start did not load base");
    word_step_a: assert property (take && en && !frame_start_i |=> // RL4
                                  mem_addr_o == 24'($past(mem_addr_o) + 24'(bvf_pkg::WORD_BYTES)))
        else $error("address did not step by one word");
    addr_even_a: assert property (!mem_addr_o[0]) // RL2
        else $error("odd fetch address");
    req_hold_a: assert property (s_mem_wait |=> mem_req_o && $stable(mem_addr_o)) // RL5
        else $error("request dropped before answer");
    idle_dark_a: assert property (!pix_valid_o |-> (rgb_o == '0) && !mono_o) // RL6
        else $error("pixel output without pixel");
endmodule // bvf_top
`default_nettype wire

// File: dv/bvf_mem_model.sv
/*
 Display memory model: answers word reads after a random delay.
 Assumes one outstanding request, held until answered.
*/
`timescale 1ns/10ps
`default_nettype none

module bvf_mem_model (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic [23:0] addr_i,
    output logic             ack_o,
    output logic      [15:0] data_o
);
    logic go;
    initial ack_o = 1'b0;
    always @(posedge clk_i) begin
        go = req_i && !ack_o && ($urandom % 3 == 0);
        ack_o  <= go;
        data_o <= go ? addr_i[16:1] : ~data_o;
    end
endmodule // bvf_mem_model
`default_nettype wire

// File: dv/testbench.sv
/*
 Testbench: registers over Wishbone, mono fetch and pixel order.
 Assumes the memory model above on the display word port.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, fs = 0, ls = 0, de = 0, pt = 0;
    logic [7:0] adr = 0;
    logic [31:0] dat = 0, rd, q, p, b;
    logic req, ack, pv, mono, mack;
    logic [11:0] rgb;
    logic [23:0] ma;
    logic [15:0] md;
    int num_errors = 0, n_tests = 0, cyc_n = 0, k;
    bvf_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .frame_start_i(fs), .line_start_i(ls), .de_i(de), .pix_tick_i(pt), .mem_req_o(req),
        .mem_addr_o(ma), .mem_ack_i(mack), .mem_data_i(md), .rgb_o(rgb), .mono_o(mono),
        .pix_valid_o(pv));
    bvf_mem_model i_mem (.clk_i(clk_i), .req_i(req), .addr_i(ma), .ack_o(mack), .data_o(md));
    initial forever #25 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1; we <= w; adr <= a; dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rd;
        cyc <= 0; we <= 0;
        @(posedge clk_i);
    endtask
    always @(posedge clk_i) if (++cyc_n == 20000) begin
        num_errors++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(32'h51F1));
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        wb(0, bvf_pkg::REG_CTRL, 0); chk(q, 0);
        wb(0, 8'hFC, 0); chk(q, 0);
        p = $urandom;
        wb(1, bvf_pkg::REG_PAL_LAST, p); wb(0, bvf_pkg::REG_PAL_LAST, 0); chk(q, p & 32'hFFF);
        $display("registers done");
        b = $urandom & 32'h3FFFFF;
        wb(1, bvf_pkg::REG_BASE_HI, b[23:16]); wb(1, bvf_pkg::REG_BASE_MID, b[15:8]);
        wb(1, bvf_pkg::REG_BASE_LO, b[7:0] | 8'h01); wb(0, bvf_pkg::REG_BASE_LO, 0);
        chk(q, {24'h0, b[7:1], 1'b0});
        b[0] = 0;
        wb(1, bvf_pkg::REG_CTRL, 32'h5);
        fs <= 1; @(posedge clk_i); fs <= 0; ls <= 1; de <= 1; @(posedge clk_i); ls <= 0;
        while (req !== 1'b1) @(posedge clk_i);
        chk(ma, b[23:0]);
        while (mack !== 1'b1) @(posedge clk_i);
        @(posedge clk_i);
        while (req !== 1'b1) @(posedge clk_i);
        chk(ma, b[23:0] + 24'h2);
        pt <= 1; k = 0;
        repeat (400) begin
            @(posedge clk_i);
            if (pv === 1'b1 && k < 16) begin
                chk(mono, b[k + 1]);
                chk(rgb, 12'h000);
                k++;
            end
        end
        chk(k, 16);
        $display("mono fetch done");
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
